// file: inc/slfs_defs.svh
`ifndef SLFS_DEFS_SVH
`define SLFS_DEFS_SVH

// ********************************************************************
// register map (word addresses on the avalon bus)
// ********************************************************************
`define SLFS_ADDR_LINE_STATUS 4'h0
`define SLFS_ADDR_FRAME_STATUS 4'h1
`define SLFS_ADDR_FRAME_IE 4'h2
`define SLFS_ADDR_RECEIVE_STATUS 4'h3
`define SLFS_ADDR_MODE 4'h4

// ********************************************************************
// line status fields
// ********************************************************************
`define SLFS_LS_TX_ACTIVE 5
`define SLFS_LS_SEARCH 4
`define SLFS_LS_CTS 3
`define SLFS_LS_DCD 2
`define SLFS_LS_TX_EN 1
`define SLFS_LS_RX_EN 0
`define SLFS_LS_TXRST_MASK 8'h2A
`define SLFS_LS_RXRST_MASK 8'h05

// ********************************************************************
// frame and receive status fields
// ********************************************************************
`define SLFS_FS_END 7
`define SLFS_FS_VALID_MASK 8'hFC
`define SLFS_RESET_VALUE 8'h00

// ********************************************************************
// mode encodings
// ********************************************************************
`define SLFS_MODE_ASYNC 2'h0
`define SLFS_MODE_BYTE 2'h1
`define SLFS_MODE_BIT 2'h2

`endif

// file: inc/slfs_pkg.sv
`default_nettype none
`include "slfs_defs.svh"

package slfs_pkg;

  typedef enum logic [1:0] {
    SLFS_ASYNC = 2'b00,
    SLFS_BYTE = 2'b01,
    SLFS_BIT = 2'b10,
    SLFS_RSVD = 2'b11
  } slfs_mode_t;

  typedef enum logic [0:0] {
    SLFS_IDLE = 1'b0,
    SLFS_ACK = 1'b1
  } slfs_bus_t;

  typedef struct packed {
    logic cts_meta;
    logic cts_sync;
    logic dcd_meta;
    logic dcd_sync;
    logic search;
    logic tx_en;
    logic rx_en;
    logic [7:0] frame_status;
    logic [7:0] frame_ie;
    logic [7:0] receive_status;
    slfs_mode_t mode;
    slfs_bus_t bus;
    logic [7:0] rdata;
  } slfs_state_t;

endpackage : slfs_pkg

`default_nettype wire

// file: logic/slfs_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "slfs_defs.svh"

// Function
// - line status ignores all host writes
// - transmitter reset clears bits five, three, one
// - receiver reset clears bits two, zero
// - hard, channel reset or stop clear all
// - line status never raises an interrupt
// - line status bits seven, six read zero
// - bit five shows sending in bit mode
// - search set by command, cleared on edge
// - bit three follows clear-to-send level
// - bit two follows carrier-detect level
// - bit one shows transmitter enabled state
// - bit zero shows receiver enabled state
// - frame status holds last bit-mode frame
// - writing one clears a frame status bit
// - rx, channel reset or stop clear frame
// - only frame end bit may interrupt
// - end-of-message read copies status bits 7..2
// - same read clears receive status register
// - frame bits mirror receive bits; 1..0 zero
// - frame-end interrupt on frame status load
// - interrupt needs frame bit and enable set
module slfs_status
  import slfs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cts_pin,
  input wire logic dcd_pin,
  input wire logic tx_sending,
  input wire logic cmd_tx_reset,
  input wire logic cmd_rx_reset,
  input wire logic cmd_channel_reset,
  input wire logic cmd_tx_enable,
  input wire logic cmd_tx_disable,
  input wire logic cmd_rx_enable,
  input wire logic cmd_rx_disable,
  input wire logic cmd_enter_search,
  input wire logic rx_level_change,
  input wire logic system_stop,
  input wire logic [7:0] rx_status_set,
  input wire logic rx_eom_read,
  output logic [7:0] line_status,
  output logic [7:0] frame_status,
  output logic [7:0] receive_status,
  output logic frame_irq
);

  slfs_state_t st_r;
  slfs_state_t st_nxt;
  logic [7:0] ls_view;
  logic wr_hit;
  logic rd_hit;

  // ******************************************************************
  // line status view
  // ******************************************************************
  always_comb begin
    ls_view = `SLFS_RESET_VALUE;
    ls_view[`SLFS_LS_TX_ACTIVE] = (st_r.mode == SLFS_BIT) &&
                                  tx_sending && st_r.tx_en;
    ls_view[`SLFS_LS_SEARCH] = (st_r.mode != SLFS_ASYNC) &&
                               st_r.search;
    ls_view[`SLFS_LS_CTS] = st_r.cts_sync && st_r.tx_en;
    ls_view[`SLFS_LS_DCD] = st_r.dcd_sync && st_r.rx_en;
    ls_view[`SLFS_LS_TX_EN] = st_r.tx_en;
    ls_view[`SLFS_LS_RX_EN] = st_r.rx_en;
  end

  function automatic logic [7:0] slfs_w1c(input logic [7:0] cur,
                                           input logic [7:0] wd);
    slfs_w1c = cur & ~wd;
  endfunction : slfs_w1c

  assign wr_hit = avs_write && avs_byteenable[0] && (st_r.bus == SLFS_IDLE);
  assign rd_hit = avs_read && (st_r.bus == SLFS_IDLE);

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.cts_meta = cts_pin;
    st_nxt.cts_sync = st_r.cts_meta;
    st_nxt.dcd_meta = dcd_pin;
    st_nxt.dcd_sync = st_r.dcd_meta;

    // receive status collects events from the receiver
    st_nxt.receive_status = (st_r.receive_status | rx_status_set) &
                            `SLFS_FS_VALID_MASK;

    // host bus
    case (st_r.bus)
      SLFS_IDLE: begin
        if (rd_hit || (avs_write && !avs_read)) begin
          st_nxt.bus = SLFS_ACK;
        end
      end
      SLFS_ACK: begin
        st_nxt.bus = SLFS_IDLE;
      end
      default: begin
        st_nxt.bus = SLFS_IDLE;
      end
    endcase

    if (rd_hit) begin
      case (avs_address)
        `SLFS_ADDR_LINE_STATUS: st_nxt.rdata = ls_view;
        `SLFS_ADDR_FRAME_STATUS: st_nxt.rdata = st_r.frame_status;
        `SLFS_ADDR_FRAME_IE: st_nxt.rdata = st_r.frame_ie;
        `SLFS_ADDR_RECEIVE_STATUS: st_nxt.rdata = st_r.receive_status;
        `SLFS_ADDR_MODE: st_nxt.rdata = {6'h00, st_r.mode};
        default: st_nxt.rdata = `SLFS_RESET_VALUE;
      endcase
    end

    // line status has no write path at all
    if (wr_hit) begin
      case (avs_address)
        `SLFS_ADDR_FRAME_STATUS: begin
          st_nxt.frame_status = slfs_w1c(st_r.frame_status,
                                         avs_writedata[7:0]);
        end
        `SLFS_ADDR_FRAME_IE: begin
          st_nxt.frame_ie = avs_writedata[7:0] & 8'h80;
        end
        `SLFS_ADDR_RECEIVE_STATUS: begin
          // a receiver event in the clear cycle must not be lost
          st_nxt.receive_status = (slfs_w1c(st_r.receive_status,
                                            avs_writedata[7:0]) |
                                   rx_status_set) & `SLFS_FS_VALID_MASK;
        end
        `SLFS_ADDR_MODE: begin
          st_nxt.mode = slfs_mode_t'(avs_writedata[1:0]);
        end
        default: begin
        end
      endcase
    end

    // end-of-message read: load after clear so the load wins
    if (rx_eom_read && st_r.mode == SLFS_BIT) begin
      st_nxt.frame_status = st_r.receive_status &
                            `SLFS_FS_VALID_MASK;
      st_nxt.receive_status = `SLFS_RESET_VALUE;
    end

    // channel commands
    if (cmd_enter_search) begin
      st_nxt.search = 1'b1;
    end else if (rx_level_change) begin
      st_nxt.search = 1'b0;
    end
    if (cmd_tx_enable) begin
      st_nxt.tx_en = 1'b1;
    end
    if (cmd_tx_disable) begin
      st_nxt.tx_en = 1'b0;
    end
    if (cmd_rx_enable) begin
      st_nxt.rx_en = 1'b1;
    end
    if (cmd_rx_disable) begin
      st_nxt.rx_en = 1'b0;
    end
    if (cmd_tx_reset) begin
      st_nxt.tx_en = 1'b0;
    end
    if (cmd_rx_reset) begin
      st_nxt.rx_en = 1'b0;
      st_nxt.frame_status = `SLFS_RESET_VALUE;
      st_nxt.receive_status = `SLFS_RESET_VALUE;
    end
    if (cmd_channel_reset || system_stop) begin
      st_nxt.tx_en = 1'b0;
      st_nxt.rx_en = 1'b0;
      st_nxt.search = 1'b0;
      st_nxt.frame_status = `SLFS_RESET_VALUE;
      st_nxt.receive_status = `SLFS_RESET_VALUE;
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // cts/dcd bits are gated by the enables so resets clear them too
  assign line_status = ls_view;
  assign frame_status = st_r.frame_status;
  assign receive_status = st_r.receive_status;
  assign frame_irq = |(st_r.frame_status & st_r.frame_ie);
  assign avs_readdata = {24'h000000, st_r.rdata};
  assign avs_waitrequest = (avs_read || avs_write) && (st_r.bus == SLFS_IDLE);

endmodule : slfs_status

`default_nettype wire

// file: testbench/slfs_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks of the status bank
// ****
module slfs_status_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cts_pin,
  input wire logic dcd_pin,
  input wire logic cmd_tx_reset,
  input wire logic cmd_rx_reset,
  input wire logic cmd_channel_reset,
  input wire logic system_stop,
  input wire logic rx_eom_read,
  input wire logic [7:0] line_status,
  input wire logic [7:0] frame_status,
  input wire logic [7:0] receive_status,
  input wire logic frame_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  chk_ls_rsvd: assert property (line_status[7:6] == 2'h0)
    else $error("line status reserved bits set");
  chk_fs_rsvd: assert property (frame_status[1:0] == 2'h0)
    else $error("frame status low bits set");
  chk_tx_rst: assert property (cmd_tx_reset |=>
    (line_status & 8'h2A) == 8'h00) else $error("tx reset left bits");
  chk_rx_rst: assert property (cmd_rx_reset |=>
    (line_status & 8'h05) == 8'h00 && frame_status == 8'h00)
    else $error("rx reset left bits");
  chk_all_clr: assert property ((cmd_channel_reset || system_stop) |=>
    line_status == 8'h00 && frame_status == 8'h00)
    else $error("channel reset or stop left bits");
  chk_irq_src: assert property (frame_irq |-> frame_status[7])
    else $error("interrupt without frame end");
  // two flops between pin and register
  chk_cts_sync: assert property (line_status[3] |-> $past(cts_pin, 2))
    else $error("cts bit ahead of pin");
  chk_dcd_sync: assert property (line_status[2] |-> $past(dcd_pin, 2))
    else $error("dcd bit ahead of pin");
  chk_eom_load: assert property ($rose(frame_status[7]) |->
    $past(rx_eom_read) && receive_status == 8'h00)
    else $error("frame end rose without load");
  cover property (frame_irq);
  cover property (system_stop);
  cover property (line_status[4]);
endmodule : slfs_status_monitor
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "slfs_defs.svh"
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cts_pin = 1'b0;
  logic dcd_pin = 1'b0;
  logic tx_sending = 1'b0;
  logic [10:0] cmd = 11'h0;
  logic [7:0] rx_status_set = 8'h00;
  logic [7:0] line_status, frame_status, receive_status, q;
  logic frame_irq;
  int bad_count = 0;
  int comparisons = 0;
  int kinds[2] = '{2, 9};
  initial forever #5 mclk = ~mclk;
  slfs_status u_slfs_status (.mclk, .srst, .ce, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .cts_pin, .dcd_pin, .tx_sending,
    .cmd_tx_reset(cmd[0]), .cmd_rx_reset(cmd[1]),
    .cmd_channel_reset(cmd[2]), .cmd_tx_enable(cmd[3]),
    .cmd_tx_disable(cmd[4]), .cmd_rx_enable(cmd[5]),
    .cmd_rx_disable(cmd[6]), .cmd_enter_search(cmd[7]),
    .rx_level_change(cmd[8]), .system_stop(cmd[9]), .rx_status_set,
    .rx_eom_read(cmd[10]), .line_status, .frame_status, .receive_status,
    .frame_irq);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // waitrequest and read data are taken at the rising edge itself
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) bad_count++;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic pulse(input int b);
    cmd[b] <= 1'b1;
    @(posedge mclk);
    cmd[b] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task automatic load(input logic [7:0] s);
    rx_status_set <= s;
    @(posedge mclk);
    rx_status_set <= 8'h00;
    pulse(10);
  endtask : load
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h00);
    ce <= 1'b0;
    pulse(3);
    ce <= 1'b1;
    rd(`SLFS_ADDR_LINE_STATUS, 8'h00);
    pulse(3);
    pulse(5);
    acc(1'b1, `SLFS_ADDR_LINE_STATUS, 8'hFF);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h03);
    cts_pin <= 1'b1;
    dcd_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h0F);
    pulse(4);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h05);
    pulse(3);
    tx_sending <= 1'b1;
    pulse(7);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h0F);
    acc(1'b1, `SLFS_ADDR_MODE, {6'h0, `SLFS_MODE_BYTE});
    pulse(7);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h1F);
    pulse(8);
    acc(1'b1, `SLFS_ADDR_MODE, {6'h0, `SLFS_MODE_BIT});
    rd(`SLFS_ADDR_LINE_STATUS, 8'h2F);
    pulse(0);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h05);
    tx_sending <= 1'b0;
    pulse(3);
    acc(1'b1, `SLFS_ADDR_FRAME_IE, 8'h80);
    load(8'hFF);
    rd(`SLFS_ADDR_FRAME_STATUS, 8'hFC);
    rd(`SLFS_ADDR_RECEIVE_STATUS, 8'h00);
    chk({7'h0, frame_irq}, 8'h01);
    acc(1'b1, `SLFS_ADDR_FRAME_STATUS, 8'h00);
    rd(`SLFS_ADDR_FRAME_STATUS, 8'hFC);
    acc(1'b1, `SLFS_ADDR_FRAME_STATUS, 8'h80);
    rd(`SLFS_ADDR_FRAME_STATUS, 8'h7C);
    chk({7'h0, frame_irq}, 8'h00);
    acc(1'b1, `SLFS_ADDR_FRAME_IE, 8'h00);
    load(8'hFF);
    chk({7'h0, frame_irq}, 8'h00);
    rx_status_set <= 8'h84;
    @(posedge mclk);
    rx_status_set <= 8'h00;
    cmd[10] <= 1'b1;
    fork
      acc(1'b1, `SLFS_ADDR_FRAME_STATUS, 8'hFF);
      begin
        @(posedge mclk);
        cmd[10] <= 1'b0;
      end
    join
    rd(`SLFS_ADDR_FRAME_STATUS, 8'h84);
    pulse(1);
    rd(`SLFS_ADDR_FRAME_STATUS, 8'h00);
    rd(`SLFS_ADDR_LINE_STATUS, 8'h0A);
    foreach (kinds[i]) begin
      pulse(3);
      pulse(5);
      load(8'h84);
      pulse(kinds[i]);
      rd(`SLFS_ADDR_LINE_STATUS, 8'h00);
      rd(`SLFS_ADDR_FRAME_STATUS, 8'h00);
    end
    give_verdict();
  end
endmodule : tb_top
bind slfs_status slfs_status_monitor u_slfs_status_monitor (.mclk, .srst,
  .cts_pin, .dcd_pin, .cmd_tx_reset, .cmd_rx_reset, .cmd_channel_reset,
  .system_stop, .rx_eom_read, .line_status, .frame_status, .receive_status,
  .frame_irq);
`default_nettype wire
